// ==== verilog/oev_map.svh ====
`ifndef OEV_MAP_SVH
`define OEV_MAP_SVH
// Register addresses (6-bit ULPI immediate space)
`define OEV_RISE_WR      6'h0D
`define OEV_RISE_SET     6'h0E
`define OEV_RISE_CLR     6'h0F
`define OEV_FALL_WR      6'h10
`define OEV_FALL_SET     6'h11
`define OEV_FALL_CLR     6'h12
`define OEV_LEVEL_ADDR   6'h13
`define OEV_LATCH_ADDR   6'h14
// Field positions and source count
`define OEV_BIT_CABLE_ID    4
`define OEV_BIT_SESSION_END 3
`define OEV_BIT_SESSION_OK  2
`define OEV_BIT_VBUS_OK     1
`define OEV_BIT_HOST_DIS    0
`define OEV_NSRC         5
// Reset values and source mask
`define OEV_EN_RESET     8'h1F
`define OEV_LATCH_RESET  8'h00
`define OEV_SRC_MASK     8'h1F
`endif

// ==== verilog/oev_pkg.sv ====
`default_nettype none
package oev_pkg;
    typedef logic [7:0] oev_byte_t;
    typedef logic [5:0] oev_addr_t;
    typedef enum logic [1:0] {
        OEV_OP_NONE  = 2'h0,
        OEV_OP_WRITE = 2'h1,
        OEV_OP_SET   = 2'h3,
        OEV_OP_CLEAR = 2'h2
    } oev_op_t;
endpackage
`default_nettype wire

// ==== verilog/oev_en_reg.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "oev_map.svh"
module oev_en_reg
    import oev_pkg::*;
#(
    parameter oev_byte_t RESET_VAL = `OEV_EN_RESET
) (
    input  wire logic      clk,
    input  wire logic      arst_n,
    input  wire oev_op_t   op,
    input  wire oev_byte_t wdata,
    output var  oev_byte_t value
);
    oev_byte_t val_d;

    // Write, bit-set or bit-clear update
    always_comb begin
        case (op)
            OEV_OP_WRITE: val_d = wdata;
            OEV_OP_SET:   val_d = value | wdata;
            OEV_OP_CLEAR: val_d = value & ~wdata;
            default:      val_d = value;
        endcase
    end

    // Holding register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            value <= RESET_VAL;
        end else begin
            value <= val_d;
        end
    end
endmodule // oev_en_reg
`default_nettype wire

// ==== verilog/oev_events.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "oev_map.svh"
module oev_events
    import oev_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      arst_n,
    input  wire logic      cable_id_ground,
    input  wire logic      session_end,
    input  wire logic      session_valid,
    input  wire logic      bit_a,
    input  wire logic      host_disconnect,
    input  wire logic      reg_wr,
    input  wire logic      reg_rd,
    input  wire oev_addr_t reg_addr,
    input  wire oev_byte_t reg_wdata,
    input  wire logic      low_power_mode,
    input  wire logic      serial_mode,
    output logic           reg_rvalid,
    output oev_byte_t      reg_rdata,
    output logic           event_pulse,
    output logic           rxcmd_req,
    output oev_byte_t      rxcmd_level
);
    oev_byte_t src;
    oev_byte_t src_prev_q, src_prev_d;
    oev_byte_t rise_en, fall_en;
    oev_byte_t latch_q, latch_d;
    oev_byte_t hit;
    oev_op_t   rise_op, fall_op;
    logic      lp_prev_q, lp_prev_d;
    logic      mode_entry;
    logic      latch_rd;
    logic      rvalid_d, event_d;
    oev_byte_t rdata_d, level_d;

    // Live source vector in documented bit order
    always_comb begin
        src = 8'h00;
        src[`OEV_BIT_CABLE_ID]    = cable_id_ground;
        src[`OEV_BIT_SESSION_END] = session_end;
        src[`OEV_BIT_SESSION_OK]  = session_valid;
        src[`OEV_BIT_VBUS_OK]     = bit_a;
        src[`OEV_BIT_HOST_DIS]    = host_disconnect;
    end

    // Address decode into write, set and clear operations
    always_comb begin
        rise_op = OEV_OP_NONE;
        fall_op = OEV_OP_NONE;
        if (reg_wr) begin
            case (reg_addr)
                `OEV_RISE_WR:  rise_op = OEV_OP_WRITE;
                `OEV_RISE_SET: rise_op = OEV_OP_SET;
                `OEV_RISE_CLR: rise_op = OEV_OP_CLEAR;
                `OEV_FALL_WR:  fall_op = OEV_OP_WRITE;
                `OEV_FALL_SET: fall_op = OEV_OP_SET;
                `OEV_FALL_CLR: fall_op = OEV_OP_CLEAR;
                default: begin
                    rise_op = OEV_OP_NONE;
                    fall_op = OEV_OP_NONE;
                end
            endcase
        end
    end

    // Rising and falling enable registers
    oev_en_reg #(.RESET_VAL(`OEV_EN_RESET)) u_rise (
        .clk    (clk),
        .arst_n (arst_n),
        .op     (rise_op),
        .wdata  (reg_wdata),
        .value  (rise_en)
    );
    oev_en_reg #(.RESET_VAL(`OEV_EN_RESET)) u_fall (
        .clk    (clk),
        .arst_n (arst_n),
        .op     (fall_op),
        .wdata  (reg_wdata),
        .value  (fall_en)
    );

    // Edge detection, latch and read path
    always_comb begin
        src_prev_d = src;
        hit = ((src & ~src_prev_q & rise_en)
             | (~src & src_prev_q & fall_en))
             & `OEV_SRC_MASK;
        lp_prev_d  = low_power_mode | serial_mode;
        mode_entry = lp_prev_d & ~lp_prev_q;
        latch_rd   = reg_rd && (reg_addr == `OEV_LATCH_ADDR);
        // Set wins over a clear in the same cycle
        latch_d = latch_q;
        if (latch_rd || mode_entry) begin
            latch_d = `OEV_LATCH_RESET;
        end
        latch_d = latch_d | hit;
        rvalid_d = reg_rd;
        case (reg_addr)
            `OEV_RISE_WR, `OEV_RISE_SET, `OEV_RISE_CLR:
                rdata_d = rise_en & `OEV_SRC_MASK;
            `OEV_FALL_WR, `OEV_FALL_SET, `OEV_FALL_CLR:
                rdata_d = fall_en & `OEV_SRC_MASK;
            `OEV_LEVEL_ADDR: rdata_d = src;
            `OEV_LATCH_ADDR: rdata_d = latch_q;
            default:         rdata_d = 8'h00;
        endcase
        if (!reg_rd) begin
            rdata_d = reg_rdata;
        end
        event_d = |hit;
        level_d = src;
    end

    // State and output registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            src_prev_q  <= 8'h00;
            latch_q     <= `OEV_LATCH_RESET;
            lp_prev_q   <= 1'b0;
            reg_rvalid  <= 1'b0;
            reg_rdata   <= 8'h00;
            event_pulse <= 1'b0;
            rxcmd_req   <= 1'b0;
            rxcmd_level <= 8'h00;
        end else begin
            src_prev_q  <= src_prev_d;
            latch_q     <= latch_d;
            lp_prev_q   <= lp_prev_d;
            reg_rvalid  <= rvalid_d;
            reg_rdata   <= rdata_d;
            event_pulse <= event_d;
            rxcmd_req   <= event_d;
            rxcmd_level <= level_d;
        end
    end

    // Enabled rising edge yields event next cycle
    property p_rise_event;
        @(posedge clk) disable iff (!arst_n)
        (|((src & ~src_prev_q & rise_en) & `OEV_SRC_MASK))
            |=> (event_pulse && rxcmd_req);
    endproperty
    a_rise_event: assert property (p_rise_event)
        else $error("enabled rise gave no event");

    // Enabled falling edge yields event next cycle
    property p_fall_event;
        @(posedge clk) disable iff (!arst_n)
        (|((~src & src_prev_q & fall_en) & `OEV_SRC_MASK))
            |=> (event_pulse && rxcmd_req);
    endproperty
    a_fall_event: assert property (p_fall_event)
        else $error("enabled fall gave no event");

    // Set address ORs byte into rise enable
    property p_rise_set;
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == `OEV_RISE_SET)
            |=> (rise_en == ($past(rise_en) | $past(reg_wdata)));
    endproperty
    a_rise_set: assert property (p_rise_set)
        else $error("rise set failed");

    // Clear address clears fall enable bits
    property p_fall_clr;
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == `OEV_FALL_CLR)
            |=> (fall_en == ($past(fall_en) & ~$past(reg_wdata)));
    endproperty
    a_fall_clr: assert property (p_fall_clr)
        else $error("fall clear failed");

    // Level read returns sampled sources
    property p_level_read;
        @(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == `OEV_LEVEL_ADDR)
            |=> (reg_rvalid && reg_rdata == $past(src));
    endproperty
    a_level_read: assert property (p_level_read)
        else $error("level read mismatch");

    // Latch read returns then clears when no new hit
    property p_latch_read;
        @(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == `OEV_LATCH_ADDR && hit == 8'h00)
            |=> (reg_rdata == $past(latch_q) && latch_q == 8'h00);
    endproperty
    a_latch_read: assert property (p_latch_read)
        else $error("latch read did not clear");

    // Every hit is recorded in the latch
    property p_latch_set;
        @(posedge clk) disable iff (!arst_n)
        (hit != 8'h00) |=> ((latch_q & $past(hit)) == $past(hit));
    endproperty
    a_latch_set: assert property (p_latch_set)
        else $error("hit not latched");

    // Mode entry clears latch
    property p_mode_clear;
        @(posedge clk) disable iff (!arst_n)
        (mode_entry && hit == 8'h00) |=> (latch_q == 8'h00);
    endproperty
    a_mode_clear: assert property (p_mode_clear)
        else $error("mode entry left latch set");

    // Reserved latch bits stay zero
    property p_latch_resv;
        @(posedge clk) disable iff (!arst_n)
        latch_q[7:5] == 3'h0;
    endproperty
    a_latch_resv: assert property (p_latch_resv)
        else $error("reserved latch bit set");

    // Plain write loads the rise enable
    property p_rise_write;
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == `OEV_RISE_WR)
            |=> (rise_en == $past(reg_wdata));
    endproperty
    a_rise_write: assert property (p_rise_write)
        else $error("rise write failed");

    // Plain write loads the fall enable
    property p_fall_write;
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == `OEV_FALL_WR)
            |=> (fall_en == $past(reg_wdata));
    endproperty
    a_fall_write: assert property (p_fall_write)
        else $error("fall write failed");

    // Set address ORs byte into fall enable
    property p_fall_set;
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == `OEV_FALL_SET)
            |=> (fall_en == ($past(fall_en) | $past(reg_wdata)));
    endproperty
    a_fall_set: assert property (p_fall_set)
        else $error("fall set failed");

    // Clear address clears rise enable bits
    property p_rise_clr;
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == `OEV_RISE_CLR)
            |=> (rise_en == ($past(rise_en) & ~$past(reg_wdata)));
    endproperty
    a_rise_clr: assert property (p_rise_clr)
        else $error("rise clear failed");

    // Rise enable reads at all three places
    property p_rise_read;
        @(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr >= `OEV_RISE_WR && reg_addr <= `OEV_RISE_CLR)
            |=> (reg_rdata == ($past(rise_en) & `OEV_SRC_MASK));
    endproperty
    a_rise_read: assert property (p_rise_read)
        else $error("rise enable read mismatch");

    // Fall enable reads at all three places
    property p_fall_read;
        @(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr >= `OEV_FALL_WR && reg_addr <= `OEV_FALL_CLR)
            |=> (reg_rdata == ($past(fall_en) & `OEV_SRC_MASK));
    endproperty
    a_fall_read: assert property (p_fall_read)
        else $error("fall enable read mismatch");

    // No event without a qualified edge
    property p_no_event;
        @(posedge clk) disable iff (!arst_n)
        (hit == 8'h00) |=> (!event_pulse && !rxcmd_req);
    endproperty
    a_no_event: assert property (p_no_event)
        else $error("event without enabled edge");

    // RXCMD level copy tracks the sources
    property p_level_copy;
        @(posedge clk) disable iff (!arst_n)
        1'b1 |=> (rxcmd_level == $past(src));
    endproperty
    a_level_copy: assert property (p_level_copy)
        else $error("rxcmd level stale");

    // Register writes never reach the latch
    property p_latch_nowrite;
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == `OEV_LATCH_ADDR && !latch_rd && !mode_entry
            && hit == 8'h00) |=> (latch_q == $past(latch_q));
    endproperty
    a_latch_nowrite: assert property (p_latch_nowrite)
        else $error("latch took a write");
endmodule // oev_events
`default_nettype wire

// ==== dv/oev_link.sv ====
`timescale 1ns/1ps
`default_nettype none
// Link-side register master; latch reads stay optional
module oev_link
    import oev_pkg::*;
(
    input  wire logic      clk,
    output logic           reg_wr,
    output logic           reg_rd,
    output oev_addr_t      reg_addr,
    output oev_byte_t      reg_wdata,
    input  wire logic      reg_rvalid,
    input  wire oev_byte_t reg_rdata
);
    // Idle bus at time zero
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 6'h00;
        reg_wdata = 8'h00;
    end
    // One-cycle write strobe, bus scrambled once released
    task automatic wr(input oev_addr_t a, input oev_byte_t d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask
    // One-cycle read strobe, answer taken mid-cycle after it
    task automatic rd(input oev_addr_t a, output oev_byte_t d,
                      output logic ok);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(negedge clk);
        ok = reg_rvalid;
        d  = reg_rdata;
    endtask
endmodule // oev_link
`default_nettype wire

// ==== dv/otg_signal_change_events_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module otg_signal_change_events_test;
    import oev_pkg::*;
    logic       clk, arst_n, lpm, ser, wr, rd, rv, ep, rq;
    logic [4:0] src;
    oev_addr_t  addr;
    oev_byte_t  wd, rdat, lvl;
    int         fail_count, tests_run;
    // Clock and reset
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        arst_n = 1'b0;
        lpm    = 1'b0;
        ser    = 1'b0;
        src    = 5'h00;
    end
    oev_events DUT (.clk(clk), .arst_n(arst_n), .cable_id_ground(src[4]),
        .session_end(src[3]), .session_valid(src[2]), .bit_a(src[1]),
        .host_disconnect(src[0]), .reg_wr(wr), .reg_rd(rd),
        .reg_addr(addr), .reg_wdata(wd), .low_power_mode(lpm),
        .serial_mode(ser), .reg_rvalid(rv), .reg_rdata(rdat),
        .event_pulse(ep), .rxcmd_req(rq), .rxcmd_level(lvl));
    oev_link link (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
        .reg_wdata(wd), .reg_rvalid(rv), .reg_rdata(rdat));
    // Verdict and end of run
    task automatic stop_test();
        $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Compare seen against expected
    task automatic check(input oev_byte_t seen, input oev_byte_t exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Register read compared against expected value
    task automatic rchk(input oev_addr_t a, input oev_byte_t exp);
        oev_byte_t d;
        logic      ok;
        link.rd(a, d, ok);
        if (ok !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t no read answer at %h", $time, a);
        end
        check(d, exp);
    endtask
    // Drive sources, look for one event within three edges
    task automatic edge_exp(input logic [4:0] nv, input logic hit);
        oev_byte_t got;
        got = 8'h00;
        @(posedge clk);
        src <= nv;
        repeat (3) begin
            @(posedge clk);
            if (ep === 1'b1) begin
                got = got + 8'h01;
                check({7'h00, rq}, 8'h01);
                check(lvl, {3'h0, nv});
            end
        end
        check(got, {7'h00, hit});
        check(lvl, {3'h0, nv});
    endtask
    // Reset values and read aliases
    task automatic t_reset();
        for (int a = 32'h0D; a <= 32'h12; a++) rchk(a[5:0], 8'h1F);
        rchk(6'h13, 8'h00);
        rchk(6'h14, 8'h00);
    endtask
    // Write, set, clear, read-only and unmapped places
    task automatic t_access();
        link.wr(6'h0D, 8'hFF);
        rchk(6'h0F, 8'h1F);
        link.wr(6'h0F, 8'h15);
        rchk(6'h0E, 8'h0A);
        link.wr(6'h0E, 8'h01);
        rchk(6'h0D, 8'h0B);
        link.wr(6'h10, 8'h00);
        link.wr(6'h11, 8'h14);
        link.wr(6'h12, 8'h04);
        rchk(6'h12, 8'h10);
        link.wr(6'h14, 8'hFF);
        link.wr(6'h13, 8'hFF);
        rchk(6'h14, 8'h00);
        rchk(6'h3A, 8'h00);
    endtask
    // Each source alone, both edge directions, masked and unmasked
    task automatic t_bits();
        oev_byte_t m;
        for (int i = 0; i < 5; i++) begin
            m = 8'h01 << i;
            link.wr(6'h0D, m);
            link.wr(6'h10, 8'h00);
            edge_exp(m[4:0], 1'b1);
            rchk(6'h13, m);
            rchk(6'h14, m);
            rchk(6'h14, 8'h00);
            edge_exp(5'h00, 1'b0);
            link.wr(6'h10, m);
            link.wr(6'h0D, 8'h00);
            edge_exp(m[4:0], 1'b0);
            edge_exp(5'h00, 1'b1);
            rchk(6'h14, m);
        end
    endtask
    // Latch cleared on entering low-power and serial mode
    task automatic t_mode();
        link.wr(6'h0D, 8'h1F);
        link.wr(6'h10, 8'h1F);
        edge_exp(5'h1F, 1'b1);
        @(posedge clk);
        lpm <= 1'b1;
        repeat (2) @(posedge clk);
        lpm <= 1'b0;
        rchk(6'h14, 8'h00);
        edge_exp(5'h00, 1'b1);
        @(posedge clk);
        ser <= 1'b1;
        repeat (2) @(posedge clk);
        ser <= 1'b0;
        rchk(6'h14, 8'h00);
    endtask
    // Mid-run reset restores enables and empties latch
    task automatic t_rst();
        edge_exp(5'h1F, 1'b1);
        edge_exp(5'h00, 1'b1);
        link.wr(6'h0D, 8'h00);
        link.wr(6'h10, 8'h00);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rchk(6'h0D, 8'h1F);
        rchk(6'h10, 8'h1F);
        rchk(6'h14, 8'h00);
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_access();
        t_bits();
        t_mode();
        t_rst();
        stop_test();
    end
endmodule // otg_signal_change_events_test
`default_nettype wire
